// ==== rtl/fpurc_top.sv ====
// Power-up, power-down and hardware reset sequencer of a serial flash.
// Summary of operation
// [R1] Below inhibit level: held reset, no response.
// [R2] Write-class commands ignored until write delay ends.
// [R3] Reads accepted after select delay, write delay regardless.
// [R4] Host keeps select high through power transitions.
// [R5] Host sends writes only after both delays.
// [R6] Power-up: standby, latch, busy, locks cleared.
// [R7] Supply falling below inhibit disables everything.
// [R8] Every reset pulse clears all lock bits.
// [R9] Reset during decode abandons command, power-on state.
// [R10] Reset aborts program or erase cycle.
// [R11] Reset lets status write finish first.
// [R12] Reset while idle gives power-on state.
// [R13] Host may hold reset low during power transitions.
// [R14] Array erased to ones, status bits zero.
// [R15] Busy flag high during self-timed cycle only.
// [R16] Reset mode, then reselect delay after release.
// [R17] Write delay counter from power-on; discards leave latch.
module fpurc_top
#(
   parameter int WRITE_DELAY_CYCLES = fpurc_pkg::WRITE_UNLOCK_CYCLES
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pins
   input wire logic supply_above_inhibit_pin,
   input wire logic supply_at_min_pin,
   input wire logic hw_reset_pin_n,
   input wire logic select_pin_n,
   input wire logic serial_clock_pin,
   // Command decoder
   input wire logic cmd_valid,
   input wire fpurc_pkg::fpurc_cmd_t cmd_kind,
   input wire logic cmd_decoding,
   input wire logic [fpurc_pkg::STATUS_W-1:0] status_wdata,
   input wire logic lock_write,
   input wire logic [1:0] lock_wdata,
   input wire logic enter_deep_pd,
   input wire logic leave_deep_pd,
   // Cycle engine
   input wire logic cycle_done,
   // Command answers
   output logic cmd_accept,
   output logic cmd_discard,
   output logic decode_abandon,
   output logic cycle_abort,
   // State seen by the rest of the device
   output logic logic_reset,
   output logic respond_enable,
   output logic read_allowed,
   output logic write_allowed,
   output logic serial_clock_rise,
   output logic write_latch_flag,
   output logic cycle_active_flag,
   output logic deep_power_down,
   output logic write_lock_bit,
   output logic lock_down_bit,
   output logic [fpurc_pkg::STATUS_W-1:0] status_word,
   output logic [7:0] erased_byte
);
   import fpurc_pkg::*;

   logic [SYNC_W-1:0] pins_sync;
   logic pwr_ok;
   logic hw_ok;
   logic sel_n_sync;
   fpurc_state_t state_reg, state_next;
   fpurc_cycle_t cycle_reg, cycle_next;
   logic [WDEL_W-1:0] wdel_cnt_reg, wdel_cnt_next;
   logic [SEL_W-1:0] sel_cnt_reg, sel_cnt_next;
   logic [RSEL_W-1:0] rsel_cnt_reg, rsel_cnt_next;
   logic latch_reg, latch_next;
   logic deep_reg, deep_next;
   logic [1:0] lock_reg, lock_next;
   logic [STATUS_W-1:0] stat_reg, stat_next;
   logic abandon_reg, abandon_next;
   logic abort_reg, abort_next;
   logic sclk_prev_reg;
   logic wdel_done;
   logic sel_done;
   logic busy;

   function automatic logic is_write_class(input fpurc_cmd_t k);
      is_write_class = (k == CMD_WRITE_ENABLE) || (k == CMD_PAGE_WRITE) || (k == CMD_PAGE_PROGRAM) ||
                       (k == CMD_PAGE_ERASE) || (k == CMD_SECTOR_ERASE);
   endfunction

   function automatic logic is_array_cycle(input fpurc_cmd_t k);
      is_array_cycle = (k == CMD_PAGE_WRITE) || (k == CMD_PAGE_PROGRAM) ||
                       (k == CMD_PAGE_ERASE) || (k == CMD_SECTOR_ERASE);
   endfunction

   fpurc_sync u_sync
   (
      .clock(clock),
      .rst_n(rst_n),
      .pins_in({serial_clock_pin, select_pin_n, hw_reset_pin_n, supply_at_min_pin, supply_above_inhibit_pin}),
      .pins_out(pins_sync)
   );

   assign pwr_ok = pins_sync[SY_SUPPLY];
   assign hw_ok = pins_sync[SY_HWRST];
   assign sel_n_sync = pins_sync[SY_SEL];

   assign wdel_done = (wdel_cnt_reg == WDEL_W'(WRITE_DELAY_CYCLES));
   assign sel_done = (sel_cnt_reg == SEL_W'(SELECT_CYCLES));
   assign busy = (cycle_reg != CYC_NONE);

   // Only the running state answers anything; off, reset and drain states stay silent.
   assign respond_enable = (state_reg == ST_RUN); // [R1] [R7] [R16]
   assign read_allowed = respond_enable && sel_done && !deep_reg; // [R3]
   assign write_allowed = read_allowed && wdel_done; // [R2]
   assign logic_reset = (state_reg == ST_POWER_OFF) || (state_reg == ST_RESET_HOLD); // [R1] [R16]
   assign serial_clock_rise = respond_enable && !sel_n_sync && pins_sync[SY_SCLK] && !sclk_prev_reg;

   always_comb
   begin
      state_next = state_reg;
      cycle_next = cycle_reg;
      wdel_cnt_next = wdel_cnt_reg;
      sel_cnt_next = sel_cnt_reg;
      rsel_cnt_next = rsel_cnt_reg;
      latch_next = latch_reg;
      deep_next = deep_reg;
      lock_next = lock_reg;
      stat_next = stat_reg;
      abandon_next = 1'b0;
      abort_next = 1'b0;
      cmd_accept = 1'b0;
      cmd_discard = 1'b0;
      // The write delay runs from power-on release and is not restarted by the reset pin.
      if (state_reg != ST_POWER_OFF && !wdel_done)
      begin
         wdel_cnt_next = wdel_cnt_reg + WDEL_W'(1); // [R17]
      end
      if (!pins_sync[SY_MIN])
      begin
         sel_cnt_next = '0;
      end
      else if (!sel_done)
      begin
         sel_cnt_next = sel_cnt_reg + SEL_W'(1); // [R3]
      end
      case (state_reg)
         ST_POWER_OFF:
         begin
            // A reset pin already held low at power-up keeps the logic in reset mode.
            state_next = hw_ok ? ST_RUN : ST_RESET_HOLD; // [R6] [R16]
         end
         ST_RUN:
         begin
            if (!hw_ok)
            begin
               lock_next = LOCK_RESET; // [R8]
               abandon_next = cmd_decoding; // [R9]
               if (cycle_reg == CYC_STATUS)
               begin
                  state_next = ST_STATUS_DRAIN; // [R11]
               end
               else
               begin
                  // Array content under an aborted cycle is left as it stands.
                  abort_next = (cycle_reg == CYC_ARRAY); // [R10]
                  cycle_next = CYC_NONE;
                  latch_next = 1'b0;
                  deep_next = 1'b0;
                  state_next = ST_RESET_HOLD; // [R9] [R12] [R16]
               end
            end
            else
            begin
               if (busy && cycle_done)
               begin
                  cycle_next = CYC_NONE; // [R15]
                  latch_next = 1'b0;
               end
               if (deep_reg && leave_deep_pd && !busy)
               begin
                  deep_next = 1'b0;
               end
               else if (!deep_reg && enter_deep_pd && !busy)
               begin
                  deep_next = 1'b1;
               end
               if (lock_write && read_allowed && !busy)
               begin
                  lock_next = lock_wdata;
               end
               if (cmd_valid)
               begin
                  if (!read_allowed)
                  begin
                     cmd_discard = 1'b1; // [R3]
                  end
                  else if (is_write_class(cmd_kind) && !write_allowed)
                  begin
                     // Blocked before the latch logic so an early write enable never sets it.
                     cmd_discard = 1'b1; // [R2] [R17]
                  end
                  else if (cmd_kind == CMD_READ)
                  begin
                     cmd_accept = 1'b1;
                  end
                  else if (busy)
                  begin
                     cmd_discard = 1'b1;
                  end
                  else if (cmd_kind == CMD_WRITE_ENABLE)
                  begin
                     cmd_accept = 1'b1;
                     latch_next = 1'b1;
                  end
                  else if (cmd_kind == CMD_WRITE_DISABLE)
                  begin
                     cmd_accept = 1'b1;
                     latch_next = 1'b0;
                  end
                  else if (!latch_reg)
                  begin
                     cmd_discard = 1'b1;
                  end
                  else if (is_array_cycle(cmd_kind))
                  begin
                     cmd_accept = 1'b1;
                     cycle_next = CYC_ARRAY; // [R15]
                  end
                  else
                  begin
                     // The new status value is held at once, so an interrupting reset cannot corrupt it.
                     cmd_accept = 1'b1;
                     cycle_next = CYC_STATUS; // [R15]
                     stat_next = status_wdata & STATUS_FIELD_MASK;
                  end
               end
            end
         end
         ST_STATUS_DRAIN:
         begin
            if (!hw_ok)
            begin
               lock_next = LOCK_RESET; // [R8]
            end
            if (cycle_done)
            begin
               cycle_next = CYC_NONE; // [R11]
               latch_next = 1'b0;
               deep_next = 1'b0;
               lock_next = LOCK_RESET;
               rsel_cnt_next = '0;
               state_next = hw_ok ? ST_RESELECT : ST_RESET_HOLD;
            end
         end
         ST_RESET_HOLD:
         begin
            lock_next = LOCK_RESET; // [R8]
            rsel_cnt_next = '0;
            if (hw_ok)
            begin
               state_next = ST_RESELECT; // [R16]
            end
         end
         ST_RESELECT:
         begin
            rsel_cnt_next = rsel_cnt_reg + RSEL_W'(1);
            if (!hw_ok)
            begin
               lock_next = LOCK_RESET; // [R8]
               state_next = ST_RESET_HOLD;
            end
            else if (rsel_cnt_reg == RSEL_W'(RESELECT_CYCLES - 1))
            begin
               state_next = ST_RUN; // [R16]
            end
         end
         default:
         begin
            state_next = ST_POWER_OFF;
         end
      endcase
      // Losing the supply overrides every update here but the status value and command answers, even a status write in flight.
      if (!pwr_ok)
      begin
         state_next = ST_POWER_OFF; // [R1] [R7]
         cycle_next = CYC_NONE;
         wdel_cnt_next = '0;
         sel_cnt_next = '0;
         rsel_cnt_next = '0;
         latch_next = 1'b0;
         deep_next = 1'b0;
         lock_next = LOCK_RESET;
         abandon_next = 1'b0;
         abort_next = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_POWER_OFF;
         cycle_reg <= CYC_NONE;
         wdel_cnt_reg <= '0;
         sel_cnt_reg <= '0;
         rsel_cnt_reg <= '0;
         latch_reg <= 1'b0;
         deep_reg <= 1'b0;
         lock_reg <= LOCK_RESET;
         stat_reg <= STATUS_RESET; // [R14]
         abandon_reg <= 1'b0;
         abort_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cycle_reg <= cycle_next;
         wdel_cnt_reg <= wdel_cnt_next;
         sel_cnt_reg <= sel_cnt_next;
         rsel_cnt_reg <= rsel_cnt_next;
         latch_reg <= latch_next;
         deep_reg <= deep_next;
         lock_reg <= lock_next;
         stat_reg <= stat_next;
         abandon_reg <= abandon_next;
         abort_reg <= abort_next;
         sclk_prev_reg <= pins_sync[SY_SCLK];
      end
   end

   assign decode_abandon = abandon_reg;
   assign cycle_abort = abort_reg;
   assign write_latch_flag = latch_reg;
   assign cycle_active_flag = busy; // [R15]
   assign deep_power_down = deep_reg;
   assign write_lock_bit = lock_reg[0];
   assign lock_down_bit = lock_reg[1];
   always_comb
   begin
      status_word = stat_reg;
      status_word[STATUS_BUSY_BIT] = busy;
      status_word[STATUS_LATCH_BIT] = latch_reg;
   end
   assign erased_byte = ERASED_BYTE; // [R14]

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_OFF_SILENT: assert property (state_reg == ST_POWER_OFF |-> !cmd_accept && !read_allowed && logic_reset) // [R1]
      else $error("Device answered while supply below inhibit level.");
   AST_PWR_LOSS: assert property (!pwr_ok |=> state_reg == ST_POWER_OFF && !cycle_active_flag && !write_latch_flag) // [R7]
      else $error("Supply loss did not disable operation.");
   AST_WRITE_BLOCK: assert property (respond_enable && hw_ok && cmd_valid && is_write_class(cmd_kind) // [R2]
      && !wdel_done |-> cmd_discard && !cmd_accept)
      else $error("Write-class command taken during write delay.");
   AST_WE_NO_LATCH: assert property (cmd_valid && cmd_kind == CMD_WRITE_ENABLE && !wdel_done && !latch_reg // [R17]
      |=> !write_latch_flag)
      else $error("Blocked write enable set the latch.");
   AST_READ_EARLY: assert property (respond_enable && hw_ok && sel_done && !deep_reg && cmd_valid // [R3]
      && cmd_kind == CMD_READ |-> cmd_accept)
      else $error("Read refused after select delay.");
   AST_POWERUP_STATE: assert property ($past(state_reg) == ST_POWER_OFF && state_reg == ST_RUN // [R6]
      |-> !write_latch_flag && !cycle_active_flag && !deep_power_down && !write_lock_bit && !lock_down_bit)
      else $error("Wrong state after power-up.");
   AST_LOCK_CLEAR: assert property (!hw_ok |=> !write_lock_bit && !lock_down_bit) // [R8]
      else $error("Lock bits not cleared by reset pulse.");
   AST_ABANDON: assert property (respond_enable && pwr_ok && !hw_ok && cmd_decoding // [R9]
      && cycle_reg != CYC_STATUS |=> decode_abandon && logic_reset)
      else $error("Decode not abandoned on reset.");
   AST_ABORT: assert property (respond_enable && pwr_ok && !hw_ok && cycle_reg == CYC_ARRAY // [R10]
      |=> cycle_abort && !cycle_active_flag)
      else $error("Array cycle not aborted on reset.");
   AST_STATUS_FINISH: assert property (state_reg == ST_STATUS_DRAIN && pwr_ok && !cycle_done // [R11]
      |=> cycle_active_flag && !respond_enable)
      else $error("Status write cut short by reset.");
   AST_CYCLE_BUSY: assert property (cmd_accept && is_array_cycle(cmd_kind) && pwr_ok // [R15]
      |=> cycle_active_flag ##0 status_word[STATUS_BUSY_BIT])
      else $error("Busy flag not raised by a started cycle.");
   AST_RESELECT: assert property (state_reg == ST_RESET_HOLD && hw_ok && pwr_ok |=> !respond_enable [*2]) // [R16]
      else $error("Responding before reselect delay.");

endmodule // fpurc_top

// ==== rtl/fpurc_pkg.sv ====
// Constants and types shared by the power-up and reset sequencer.
package fpurc_pkg;

   localparam int CLOCK_PERIOD_NS = 8;

   // Write-class commands stay blocked for this long after the supply passes the inhibit level.
   localparam int WRITE_UNLOCK_DELAY_MS = 10;
   localparam int WRITE_UNLOCK_CYCLES = (WRITE_UNLOCK_DELAY_MS * 1000000) / CLOCK_PERIOD_NS;
   localparam int WDEL_W = 21;

   // Reads are served once this long has passed with the supply at its minimum.
   localparam int SELECT_AFTER_SUPPLY_DELAY_US = 30;
   localparam int SELECT_CYCLES = (SELECT_AFTER_SUPPLY_DELAY_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SEL_W = 12;

   // Quiet time after the reset pin is released.
   localparam int RESELECT_AFTER_CLEAR_DELAY_NS = 100;
   localparam int RESELECT_CYCLES = (RESELECT_AFTER_CLEAR_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int RSEL_W = 8;

   // Status word layout.
   localparam int STATUS_W = 8;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_LATCH_BIT = 1;
   localparam logic [7:0] STATUS_FIELD_MASK = 8'h9c;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [1:0] LOCK_RESET = 2'h0;

   // Positions of the pin inputs in the synchroniser.
   localparam int SY_SUPPLY = 0;
   localparam int SY_MIN = 1;
   localparam int SY_HWRST = 2;
   localparam int SY_SEL = 3;
   localparam int SY_SCLK = 4;
   localparam int SYNC_W = 5;
   localparam logic [4:0] SYNC_RESET = 5'h0c;

   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE_ENABLE,
      CMD_WRITE_DISABLE,
      CMD_PAGE_WRITE,
      CMD_PAGE_PROGRAM,
      CMD_PAGE_ERASE,
      CMD_SECTOR_ERASE,
      CMD_STATUS_WRITE
   } fpurc_cmd_t;

   typedef enum logic [1:0] {
      CYC_NONE,
      CYC_ARRAY,
      CYC_STATUS
   } fpurc_cycle_t;

   typedef enum logic [2:0] {
      ST_POWER_OFF,
      ST_RUN,
      ST_RESET_HOLD,
      ST_STATUS_DRAIN,
      ST_RESELECT
   } fpurc_state_t;

endpackage

// ==== rtl/fpurc_sync.sv ====
// Two-stage synchroniser for the pin inputs.
module fpurc_sync
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pins and their synchronised copies
   input wire logic [fpurc_pkg::SYNC_W-1:0] pins_in,
   output logic [fpurc_pkg::SYNC_W-1:0] pins_out
);
   import fpurc_pkg::*;

   logic [SYNC_W-1:0] stage1_reg;
   logic [SYNC_W-1:0] stage2_reg;

   // Reset values assume a deselected bus with the reset pin released.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stage1_reg <= SYNC_RESET;
         stage2_reg <= SYNC_RESET;
      end
      else
      begin
         stage1_reg <= pins_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign pins_out = stage2_reg;

endmodule // fpurc_sync

// ==== test/fpurc_host_model.sv ====
// Host controller model that frames serial clock bursts with the select pin.
module fpurc_host_model
(
   // Clock
   input wire logic clock,
   // Frame request from the bench
   input wire logic frame_go,
   input wire logic [3:0] frame_bits,
   output logic frame_busy,
   // Pins
   output logic select_pin_n,
   output logic serial_clock_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   // The serial clock rests low between frames, so every edge the device sees is real.
   initial
   begin
      select_pin_n = 1'b1;
      serial_clock_pin = 1'b0;
      frame_busy = 1'b0;
      forever
      begin
         @(posedge clock);
         // Frames are only requested once the device answers again after reset.
         if (frame_go === 1'b1)
         begin
            // Starting a fraction off the edge keeps every pin change clear of the sampling edge.
            #0.2;
            frame_busy = 1'b1;
            select_pin_n = 1'b0;
            repeat (frame_bits)
            begin
               #62.5 serial_clock_pin = 1'b1;
               #62.5 serial_clock_pin = 1'b0;
            end
            #62.5 select_pin_n = 1'b1;
            frame_busy = 1'b0;
         end
      end
   end
endmodule // fpurc_host_model

// ==== test/tb.sv ====
// Self-checking bench for the power-up and reset sequencer.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fpurc_pkg::*;

   localparam int WDC = 6000;
   logic clock, rst_n, sup, smin, hw_n, sel_n, sclk, cmd_valid, cmd_decoding, lock_write;
   logic enter_deep_pd, leave_deep_pd, cycle_done, frame_go, frame_busy;
   fpurc_cmd_t cmd_kind;
   logic [7:0] status_wdata, status_word, erased_byte;
   logic [1:0] lock_wdata;
   logic cmd_accept, cmd_discard, decode_abandon, cycle_abort, logic_reset, respond_enable;
   logic read_allowed, write_allowed, serial_clock_rise, write_latch_flag, cycle_active_flag;
   logic deep_power_down, write_lock_bit, lock_down_bit;
   int error_cnt = 0;
   int num_checks = 0;
   int rise_cnt, abort_cnt, abandon_cnt;

   fpurc_top #(.WRITE_DELAY_CYCLES(WDC)) u_fpurc_top (.clock(clock), .rst_n(rst_n),
      .supply_above_inhibit_pin(sup), .supply_at_min_pin(smin), .hw_reset_pin_n(hw_n),
      .select_pin_n(sel_n), .serial_clock_pin(sclk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_decoding(cmd_decoding), .status_wdata(status_wdata), .lock_write(lock_write),
      .lock_wdata(lock_wdata), .enter_deep_pd(enter_deep_pd), .leave_deep_pd(leave_deep_pd),
      .cycle_done(cycle_done), .cmd_accept(cmd_accept), .cmd_discard(cmd_discard),
      .decode_abandon(decode_abandon), .cycle_abort(cycle_abort), .logic_reset(logic_reset),
      .respond_enable(respond_enable), .read_allowed(read_allowed), .write_allowed(write_allowed),
      .serial_clock_rise(serial_clock_rise), .write_latch_flag(write_latch_flag),
      .cycle_active_flag(cycle_active_flag), .deep_power_down(deep_power_down),
      .write_lock_bit(write_lock_bit), .lock_down_bit(lock_down_bit), .status_word(status_word),
      .erased_byte(erased_byte));

   fpurc_host_model u_fpurc_host_model (.clock(clock), .frame_go(frame_go), .frame_bits(4'h8),
      .frame_busy(frame_busy), .select_pin_n(sel_n), .serial_clock_pin(sclk));

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Pulses are counted at the edge, where the registered value is still settled.
   always @(posedge clock)
   begin
      if (serial_clock_rise === 1'b1) rise_cnt++;
      if (cycle_abort === 1'b1) abort_cnt++;
      if (decode_abandon === 1'b1) abandon_cnt++;
   end

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic cond(input int sel);
      case (sel)
         0: return respond_enable;
         1: return read_allowed;
         2: return write_allowed;
         3: return logic_reset;
         default: return ~frame_busy;
      endcase
   endfunction

   task automatic wait_on(input int sel, input int bound);
      int n;
      n = 0;
      while (cond(sel) !== 1'b1)
      begin
         @(posedge clock);
         #1;
         n++;
         if (n > bound)
         begin
            error_cnt++;
            close_out();
         end
      end
   endtask

   // Expected answer is {accept, discard}; both low means the device stays silent.
   task automatic send(input fpurc_cmd_t k, input logic [1:0] exp);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      #1;
      check({7'h0, cmd_accept}, {7'h0, exp[1]});
      check({7'h0, cmd_discard}, {7'h0, exp[0]});
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1;
   endtask

   task automatic strobe(input int sel);
      @(posedge clock);
      case (sel)
         0: enter_deep_pd <= 1'b1;
         1: leave_deep_pd <= 1'b1;
         2: lock_write <= 1'b1;
         default: cycle_done <= 1'b1;
      endcase
      @(posedge clock);
      {enter_deep_pd, leave_deep_pd, lock_write, cycle_done} <= 4'h0;
      #1;
   endtask

   task automatic pin_reset(input logic v);
      @(posedge clock);
      hw_n <= v;
   endtask

   task automatic power_up();
      check(logic_reset, 1'b1);
      check(respond_enable, 1'b0);
      send(CMD_READ, 2'b00);
      @(posedge clock);
      sup <= 1'b1;
      smin <= 1'b1;
      wait_on(0, 10);
      check(deep_power_down, 1'b0);
      check({lock_down_bit, write_lock_bit}, LOCK_RESET);
      check(write_latch_flag, 1'b0);
      check(cycle_active_flag, 1'b0);
      check(status_word, 8'h00);
      check(erased_byte, 8'hff);
   endtask

   task automatic early_access();
      fpurc_cmd_t wk[5] = '{CMD_WRITE_ENABLE, CMD_PAGE_WRITE, CMD_PAGE_PROGRAM, CMD_PAGE_ERASE, CMD_SECTOR_ERASE};
      send(CMD_READ, 2'b01);
      wait_on(1, 4000);
      send(CMD_READ, 2'b10);
      foreach (wk[i]) send(wk[i], 2'b01);
      check(write_latch_flag, 1'b0);
      check(write_allowed, 1'b0);
   endtask

   task automatic program_cycle();
      wait_on(2, 3000);
      send(CMD_WRITE_ENABLE, 2'b10);
      check(write_latch_flag, 1'b1);
      send(CMD_PAGE_PROGRAM, 2'b10);
      check(cycle_active_flag, 1'b1);
      send(CMD_PAGE_ERASE, 2'b01);
      strobe(3);
      check(cycle_active_flag, 1'b0);
      send(CMD_WRITE_ENABLE, 2'b10);
      send(CMD_WRITE_DISABLE, 2'b10);
      check(write_latch_flag, 1'b0);
      rise_cnt = 0;
      @(posedge clock);
      frame_go <= 1'b1;
      @(posedge clock);
      frame_go <= 1'b0;
      repeat (2) @(posedge clock);
      wait_on(4, 300);
      repeat (4) @(posedge clock);
      check(rise_cnt[7:0], 8'h08);
   endtask

   task automatic reset_in_cycle();
      @(posedge clock);
      lock_wdata <= 2'h3;
      strobe(2);
      check({lock_down_bit, write_lock_bit}, 2'h3);
      send(CMD_WRITE_ENABLE, 2'b10);
      send(CMD_PAGE_PROGRAM, 2'b10);
      abort_cnt = 0;
      abandon_cnt = 0;
      pin_reset(1'b0);
      cmd_decoding <= 1'b1;
      wait_on(3, 10);
      @(posedge clock);
      #1;
      check(abort_cnt[7:0], 8'h01);
      check(abandon_cnt[7:0], 8'h01);
      check({lock_down_bit, write_lock_bit}, 2'h0);
      check({write_latch_flag, cycle_active_flag}, 2'h0);
      check(respond_enable, 1'b0);
      pin_reset(1'b1);
      cmd_decoding <= 1'b0;
      repeat (10) @(posedge clock);
      #1;
      check(respond_enable, 1'b0);
      wait_on(0, 20);
   endtask

   task automatic reset_in_status();
      @(posedge clock);
      status_wdata <= 8'hff;
      send(CMD_WRITE_ENABLE, 2'b10);
      send(CMD_STATUS_WRITE, 2'b10);
      pin_reset(1'b0);
      repeat (8) @(posedge clock);
      #1;
      check(logic_reset, 1'b0);
      check(cycle_active_flag, 1'b1);
      check(status_word & STATUS_FIELD_MASK, STATUS_FIELD_MASK);
      strobe(3);
      wait_on(3, 5);
      check(cycle_active_flag, 1'b0);
      check(status_word & STATUS_FIELD_MASK, STATUS_FIELD_MASK);
      pin_reset(1'b1);
      wait_on(0, 30);
   endtask

   task automatic idle_reset();
      @(posedge clock);
      lock_wdata <= 2'h1;
      strobe(2);
      check({lock_down_bit, write_lock_bit}, 2'h1);
      pin_reset(1'b0);
      wait_on(3, 10);
      pin_reset(1'b1);
      wait_on(0, 30);
      check({lock_down_bit, write_lock_bit}, 2'h0);
      check({write_latch_flag, cycle_active_flag}, 2'h0);
      check(read_allowed, 1'b1);
   endtask

   task automatic power_down();
      strobe(0);
      check(deep_power_down, 1'b1);
      send(CMD_READ, 2'b01);
      strobe(1);
      check(deep_power_down, 1'b0);
      strobe(0);
      @(posedge clock);
      sup <= 1'b0;
      smin <= 1'b0;
      wait_on(3, 10);
      check(respond_enable, 1'b0);
      send(CMD_READ, 2'b00);
      pin_reset(1'b0);
      @(posedge clock);
      sup <= 1'b1;
      smin <= 1'b1;
      repeat (6)
      begin
         @(posedge clock);
         #1;
         check(respond_enable, 1'b0);
      end
      pin_reset(1'b1);
      wait_on(0, 30);
      check(deep_power_down, 1'b0);
      check({read_allowed, write_allowed}, 2'h0);
   endtask

   initial
   begin
      {rst_n, sup, smin, cmd_valid, cmd_decoding, lock_write, frame_go} = 7'h0;
      {enter_deep_pd, leave_deep_pd, cycle_done} = 3'h0;
      hw_n = 1'b1;
      cmd_kind = CMD_READ;
      status_wdata = 8'h00;
      lock_wdata = 2'h0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      power_up();
      early_access();
      program_cycle();
      reset_in_cycle();
      reset_in_status();
      idle_reset();
      power_down();
      close_out();
   end
endmodule // tb
